// ---- sim/ethernet_tx_queue_host_side_tb.sv ----
// bench for the transmit queue: host bus tasks and queued frames
module ethernet_tx_queue_host_side_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import txq_pkg::*;
  logic core_clk, reset = 1'b1, cmd = 1'b0, cs_n = 1'b1;
  logic rd_n = 1'b1, wr_n = 1'b1, stall = 1'b0;
  logic [15:0] sd_in = 16'h0000, sd_out, mac_data, rdata;
  logic sd_oe_n, intr_n, mac_valid, mac_ready, mac_last, mac_enable;
  mac_cfg_s mac_cfg;
  int mismatches = 0, n_compared = 0, i, f;
  ethernet_tx_queue_host_side dut (.core_clk(core_clk), .reset(reset),
    .cmd(cmd), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sd_in(sd_in),
    .sd_out(sd_out), .sd_oe_n(sd_oe_n), .intr_n(intr_n),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_data(mac_data),
    .mac_last(mac_last), .mac_enable(mac_enable), .mac_cfg(mac_cfg));
  mac_sink sink (.core_clk(core_clk), .mac_valid(mac_valid),
    .mac_ready(mac_ready), .word({mac_last, mac_data}), .stall(stall));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task chk(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      mismatches++;
    end
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait for the sink to hold t words
  task wait_words(input int t);
    int k;
    for (k = 0; k < 3000 && sink.n < t; k++) @(negedge core_clk);
    if (k == 3000) begin
      mismatches++;
      results();
    end
  endtask
  // ----------------------------------------------------------------
  // host bus cycles
  // ----------------------------------------------------------------
  // strobes held 4 clocks so the 2-flop sync never loses them
  task cyc(input logic c, input logic w, input logic [15:0] d);
    cmd = c;
    sd_in = d;
    cs_n = 1'b0;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rdata = sd_oe_n ? 16'hdead : sd_out;
    {cs_n, rd_n, wr_n} = 3'b111;
    sd_in = ~d;  // released bus shows no stale value
    repeat (4) @(negedge core_clk);
  endtask
  // address word: byte enables steer to the upper half word when a[1] is set
  function automatic logic [15:0] aw(input logic [7:0] a);
    return {a[1] ? 4'hc : 4'h3, 4'h0, a[7:2], 2'b00};
  endfunction
  task wr(input logic [7:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b1, aw(a));
    cyc(1'b0, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    cyc(1'b1, 1'b1, aw(a));
    cyc(1'b0, 1'b0, 16'h0000);
    chk({1'b0, rdata}, {1'b0, exp});
  endtask
  // one frame through a data session, words {base, index}
  task frame(input logic [15:0] cw, input int len, input logic [7:0] b);
    wr(8'h82, 16'h0008);
    cyc(1'b1, 1'b1, aw(8'h84));
    cyc(1'b0, 1'b1, cw);
    cyc(1'b0, 1'b1, len[15:0]);
    for (i = 0; i < len / 2; i++) cyc(1'b0, 1'b1, {b, i[7:0]});
    wr(8'h82, 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    rd(8'h70, 16'h0000);
    rd(8'h78, 16'h1800);
    rd(8'h74, 16'h0000);
    wr(8'h70, 16'hffff);
    rd(8'h70, 16'h01ef);
    chk({10'h0, mac_cfg}, 17'h0007f);
    wr(8'h70, 16'h0001);
    chk({16'h0, mac_enable}, 17'h1);
    wr(8'h90, 16'h4040);
    wr(8'h84, 16'h4000);
    frame(16'h8015, 6, 8'ha0);
    wr(8'h80, 16'h0001);
    wait_words(3);
    for (i = 0; i < 3; i++) chk(sink.got[i], {i == 2, 8'ha0, i[7:0]});
    rd(8'h72, 16'h0015);
    rd(8'h92, 16'h4000);
    chk({16'h0, intr_n}, 17'h0);
    rd(8'h80, 16'h0000);
    rd(8'h78, 16'h1800);
    wr(8'h92, 16'hffff);
    rd(8'h92, 16'h0000);
    chk({16'h0, intr_n}, 17'h1);
    stall = 1'b1;
    wr(8'h80, 16'h0004);
    for (f = 1; f < 3; f++) frame({10'h0, f[5:0]}, 16, 8'hb0 + f[7:0]);
    rd(8'h78, 16'h17d8);
    chk({16'h0, mac_valid}, 17'h1);
    chk(17'(sink.n), 17'd3);
    stall = 1'b0;
    wait_words(19);
    for (i = 0; i < 16; i++)
      chk(sink.got[3 + i], {i % 8 == 7, 8'hb1 + i[7:3], 5'h0, i[2:0]});
    rd(8'h72, 16'h0002);
    rd(8'h92, 16'h0000);
    rd(8'h78, 16'h1800);
    wr(8'h9e, 16'd1536);
    wr(8'h80, 16'h0006);
    rd(8'h92, 16'h0040);
    chk({16'h0, intr_n}, 17'h0);
    rd(8'h80, 16'h0004);
    wr(8'h90, 16'h4000);
    chk({16'h0, intr_n}, 17'h1);
    wr(8'h80, 16'h0001);
    rd(8'h80, 16'h0000);
    results();
  end
endmodule

// ---- sim/mac_sink.sv ----
// mac side partner model: takes stream words, paces and stalls
module mac_sink (
  // clock
  input  wire logic        core_clk,
  // stream from the queue
  input  wire logic        mac_valid,
  output      logic        mac_ready,
  input  wire logic [16:0] word,
  // pacing from the bench
  input  wire logic        stall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        slow_q = 1'b0;  // ready only every other cycle
  logic [16:0] got [0:31];     // captured {last, data}
  int          n = 0;          // words taken so far
  // slow pacing lets words back up in the fifo even when not stalled
  assign mac_ready = ~stall & slow_q;
  // capture each accepted word
  always @(posedge core_clk) begin
    slow_q <= ~slow_q;
    if (mac_valid && mac_ready) begin
      got[n] <= word;
      n <= n + 1;
    end
  end
endmodule

// ---- src/ethernet_tx_queue_host_side.sv ----
// transmit queue of the ethernet controller, host side, with its fifo

// ------------------------------------------------------------------
// small word fifo between queue memory and the mac
// ------------------------------------------------------------------
module txq_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;     // write slot
    logic [AW-1:0] rp;     // read slot
    logic [AW:0]   count;  // words held
  } fifo_state_s;

  fifo_state_s      s_q;
  fifo_state_s      s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // full and empty straight from the count
  assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next pointers; depth must be a power of two
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + AW'(1);
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s_q.wp] <= in_data;
    end
  end

  a_fifo_count_up: // R3
    assert property (@(posedge core_clk) disable iff (reset)
      push && !pop |=> s_q.count == $past(s_q.count) + (AW+1)'(1))
      else $error("fifo count did not follow a push");
endmodule

// Operation
// R1: control word, byte count, then frame data
// R2: crc bit decides whether host supplies crc
// R3: frames pipeline while queue memory has room
// R4: status shows frame now on the mac
// R5: host swaps bytes in big endian mode
// R6: one word aligned control word per frame
// R7: irq_on_complete raises done interrupt after frame
// R8: frame_tag reported in transmit status
// R9: host writes nonzero tx_length in bits 10:0
// R10: host frame data at most 2000 bytes
// R11: all frame bytes sent unchanged, no insertion
// R12: length/type field passed through as data
// R13: tx_control enables flow, pad, crc, block
// R14: tx_control bits 8:5 enable checksums
// R15: tx_free_space reports free bytes, 13 bits
// R16: manual enqueue bit clears when frame done
// R17: space request raises status bit 6
// R18: auto enqueue queues every prepared frame
// R19: rx_queue_command bit 3 opens data session
// R20: pointer bit 14 auto-increments on access
// R21: int_enable bits 14 and 6 gate interrupts
// R22: writing one clears int_status bits
// R23: host programs space request in dwords
// R24: finished frame storage returns to free space
module ethernet_tx_queue_host_side (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // host shared bus pins
  input  wire logic                 cmd,
  input  wire logic                 cs_n,
  input  wire logic                 rd_n,
  input  wire logic                 wr_n,
  input  wire logic [15:0]          sd_in,
  output      logic [15:0]          sd_out,
  output      logic                 sd_oe_n,
  output      logic                 intr_n,
  // mac side stream
  output      logic                 mac_valid,
  input  wire logic                 mac_ready,
  output      logic [15:0]          mac_data,
  output      logic                 mac_last,
  output      logic                 mac_enable,
  output      txq_pkg::mac_cfg_s    mac_cfg
);
  import txq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pin_s        s1;          // first sync stage, read by s2 only
    pin_s        s2;          // second sync stage
    logic        wr_n3;       // delayed strobe for edge detect
    logic [15:0] addr_word;   // latched address and byte enables
    logic [15:0] tx_control;
    logic [15:0] int_enable;
    logic [15:0] int_status;
    logic [15:0] space_req;
    logic [2:0]  txq_cmd;
    logic        session;     // host data session open
    logic        autoinc;
    logic [10:0] ptr;         // byte offset in prepared frame
    logic [10:0] prep_len;    // tx_length of prepared frame
    logic        prep_valid;  // prepared frame holds data
    logic [11:0] wr_base;     // word base of prepared frame
    logic [11:0] rd_base;     // word base of frame in flight
    logic [11:0] rd_addr;
    logic [11:0] used;        // committed words
    logic [7:0]  frames;      // committed frames
    rd_state_e   st;
    logic [15:0] ctrl;        // control word of frame in flight
    logic [10:0] cur_len;
    logic [10:0] remain;      // data words still to push
    logic [5:0]  status_tag;
    logic        status_busy;
    logic        irq;
    logic        sd_drive;
    logic [15:0] sd_q;
  } state_s;

  state_s      s_q;               // registered state
  state_s      s_d;               // next state
  logic [15:0] qmem [QUEUE_WORDS]; // transmit queue memory
  logic        mem_we;
  logic [11:0] mem_waddr;
  logic [15:0] mem_rdata;
  fifo_word_s  fifo_in;
  fifo_word_s  fifo_out;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        mac_last_fire;     // last word taken by the mac
  logic        wr_event;          // host write strobe edge
  logic        queue_access;      // data goes to queue memory
  logic [7:0]  off;
  logic [15:0] rdata;
  logic [15:0] int_clear;
  logic        commit_req;
  logic        manual_req;
  logic        commit_ok;
  logic        done;
  logic        space_hit;
  logic [11:0] commit_words;
  logic [11:0] done_words;
  logic [11:0] free_words;
  logic [12:0] free_bytes;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // circular add inside queue memory
  function automatic logic [11:0] wrap_add(input logic [11:0] a,
                                           input logic [11:0] b);
    logic [12:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= {1'b0, QUEUE_WORDS}) begin
      sum = sum - {1'b0, QUEUE_WORDS};
    end
    return sum[11:0];
  endfunction

  // words of a frame: two header words plus data, dword aligned
  function automatic logic [11:0] frame_words(input logic [10:0] len);
    logic [11:0] w;
    w = 12'h002 + (({1'b0, len} + 12'h001) >> 1);
    w = w + {11'h000, w[0]};
    return w;
  endfunction

  // register offset from address bits 7:2 and upper byte enables
  function automatic logic [7:0] reg_off(input logic [15:0] aw);
    return {aw[7:2], (|aw[15:14]) ? 2'b10 : 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sd_out     = s_q.sd_q;
  assign sd_oe_n    = !s_q.sd_drive;
  assign intr_n     = !s_q.irq;
  assign mac_enable = s_q.tx_control[TXC_BLOCK_EN]; // R13
  assign mac_cfg    = '{flow_en: s_q.tx_control[TXC_FLOW],  // R13
                        pad_en:  s_q.tx_control[TXC_PAD],
                        crc_en:  s_q.tx_control[TXC_CRC],   // R2
                        csum_en: s_q.tx_control[8:5]};      // R14
  assign mac_data   = fifo_out.data;
  assign mac_last   = fifo_out.last;
  assign mac_last_fire = mac_valid && mac_ready && fifo_out.last;
  assign mem_rdata  = qmem[s_q.rd_addr];
  assign free_words = QUEUE_WORDS - s_q.used;
  assign free_bytes = {free_words, 1'b0}; // R15

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // pins pass two flops before use
    s_d.s1    = '{cmd: cmd, cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                  sd: sd_in};
    s_d.s2    = s_q.s1;
    s_d.wr_n3 = s_q.s2.wr_n;
    wr_event  = !s_q.s2.wr_n && s_q.wr_n3 && !s_q.s2.cs_n;
    off       = reg_off(s_q.addr_word);
    // only rx_queue_command stays reachable during a session
    queue_access = s_q.session && (off != OFF_RX_QUEUE_COMMAND); // R19
    mem_we     = 1'b0;
    mem_waddr  = wrap_add(s_q.wr_base, {2'b00, s_q.ptr[10:1]}); // R1 R6
    int_clear  = RESET_WORD;
    commit_req = 1'b0;
    manual_req = 1'b0;
    done       = 1'b0;
    fifo_in_valid = 1'b0;
    // data forwarded untouched, addresses and type included
    fifo_in    = '{last: (s_q.remain == 11'h001),
                   data: mem_rdata}; // R11 R12

    // host writes
    if (wr_event) begin
      if (s_q.s2.cmd) begin
        s_d.addr_word = s_q.s2.sd;
      end else if (queue_access) begin
        mem_we = 1'b1;
        s_d.prep_valid = 1'b1;
        // second word of the frame is the byte count
        if (s_q.ptr[10:1] == 10'h001) begin
          s_d.prep_len = s_q.s2.sd[10:0]; // R1
        end
        if (s_q.autoinc) begin
          s_d.ptr = s_q.ptr + 11'h002; // R20
        end
      end else begin
        case (off)
          OFF_TX_CONTROL: begin
            s_d.tx_control = s_q.s2.sd & TX_CONTROL_MASK; // R13 R14
          end
          OFF_TX_QUEUE_COMMAND: begin
            // a second start while one is pending is ignored
            if (s_q.s2.sd[QC_MANUAL] && !s_q.txq_cmd[QC_MANUAL]) begin
              commit_req = 1'b1; // R16
              manual_req = 1'b1;
            end
            if (s_q.s2.sd[QC_SPACE]) begin
              s_d.txq_cmd[QC_SPACE] = 1'b1; // R17
            end
            s_d.txq_cmd[QC_AUTO] = s_q.s2.sd[QC_AUTO];
          end
          OFF_RX_QUEUE_COMMAND: begin
            s_d.session = s_q.s2.sd[RQ_SESSION]; // R19
            // closing a session queues the frame in auto mode
            if (s_q.session && !s_q.s2.sd[RQ_SESSION] &&
                s_q.txq_cmd[QC_AUTO]) begin
              commit_req = 1'b1; // R18
            end
          end
          OFF_TX_DATA_POINTER: begin
            s_d.autoinc = s_q.s2.sd[DP_AUTOINC]; // R20
            s_d.ptr     = s_q.s2.sd[10:0];
          end
          OFF_INT_ENABLE: begin
            s_d.int_enable = s_q.s2.sd; // R21
          end
          OFF_INT_STATUS: begin
            int_clear = s_q.s2.sd; // R22
          end
          OFF_TX_SPACE_REQUEST: begin
            s_d.space_req = s_q.s2.sd;
          end
          default: begin
            // unmapped or read-only: write ignored
          end
        endcase
      end
    end

    // enqueue only what fits, so the queue never overruns
    commit_words = frame_words(s_q.prep_len);
    commit_ok = commit_req && s_q.prep_valid &&
                (s_q.prep_len != 11'h000) &&
                (commit_words <= free_words) &&
                (s_q.frames != 8'hff); // R3
    if (commit_ok) begin
      s_d.wr_base    = wrap_add(s_q.wr_base, commit_words); // R3
      s_d.prep_valid = 1'b0;
      s_d.ptr        = 11'h000;
      if (manual_req) begin
        s_d.txq_cmd[QC_MANUAL] = 1'b1; // R16
      end
    end

    // reader: queue memory into the fifo
    case (s_q.st)
      RD_IDLE: begin
        if (s_q.tx_control[TXC_BLOCK_EN] && (s_q.frames != 8'h00)) begin
          s_d.rd_addr = s_q.rd_base; // R13
          s_d.st      = RD_CTRL;
        end
      end
      RD_CTRL: begin
        s_d.ctrl    = mem_rdata; // R1
        s_d.rd_addr = wrap_add(s_q.rd_addr, 12'h001);
        s_d.st      = RD_LEN;
      end
      RD_LEN: begin
        s_d.cur_len     = mem_rdata[10:0];
        s_d.remain      = 11'((({1'b0, mem_rdata[10:0]}) + 12'h001) >> 1);
        s_d.status_tag  = s_q.ctrl[5:0]; // R4 R8
        s_d.status_busy = 1'b1;
        s_d.rd_addr     = wrap_add(s_q.rd_addr, 12'h001);
        s_d.st          = RD_DATA;
      end
      RD_DATA: begin
        fifo_in_valid = 1'b1;
        // a full fifo stalls the reader here
        if (fifo_in_ready) begin
          s_d.rd_addr = wrap_add(s_q.rd_addr, 12'h001);
          s_d.remain  = s_q.remain - 11'h001;
          if (s_q.remain == 11'h001) begin
            s_d.st = RD_DRAIN;
          end
        end
      end
      RD_DRAIN: begin
        if (mac_last_fire) begin
          done            = 1'b1;
          s_d.status_busy = 1'b0;
          s_d.rd_base     = wrap_add(s_q.rd_base,
                                     frame_words(s_q.cur_len)); // R24
          s_d.st          = RD_IDLE;
        end
      end
      default: begin
        s_d.st = RD_IDLE;
      end
    endcase

    // space accounting, both ends may move in one cycle
    done_words = frame_words(s_q.cur_len);
    s_d.used = s_q.used + (commit_ok ? commit_words : 12'h000)
                        - (done ? done_words : 12'h000); // R24
    s_d.frames = s_q.frames + {7'h00, commit_ok} - {7'h00, done};
    // a commit in the same cycle keeps the bit set
    if (done && (s_q.frames == 8'h01) && !commit_ok) begin
      s_d.txq_cmd[QC_MANUAL] = 1'b0; // R16
    end

    // interrupt status: clear first, so a same-cycle set wins
    s_d.int_status = s_q.int_status & ~int_clear & INT_MASK; // R22
    if (done && s_q.ctrl[CW_IRQ]) begin
      s_d.int_status[INT_TX_DONE] = 1'b1; // R7
    end
    space_hit = s_q.txq_cmd[QC_SPACE] &&
                ({5'h00, free_bytes} >= {s_q.space_req, 2'b00});
    if (space_hit) begin
      s_d.int_status[INT_SPACE] = 1'b1; // R17
      s_d.txq_cmd[QC_SPACE]     = 1'b0;
    end
    s_d.irq = |(s_d.int_status & s_q.int_enable); // R21

    // register reads; queue data itself is not readable here
    case (off)
      OFF_TX_CONTROL:       rdata = s_q.tx_control;
      OFF_TX_STATUS:        rdata = {s_q.status_busy, 9'h000,
                                     s_q.status_tag}; // R4 R8
      OFF_TX_FREE_SPACE:    rdata = {3'h0, free_bytes}; // R15
      OFF_TX_QUEUE_COMMAND: rdata = {13'h0000, s_q.txq_cmd};
      OFF_RX_QUEUE_COMMAND: rdata = {12'h000, s_q.session, 3'h0};
      OFF_TX_DATA_POINTER:  rdata = {1'b0, s_q.autoinc, 3'h0, s_q.ptr};
      OFF_INT_ENABLE:       rdata = s_q.int_enable;
      OFF_INT_STATUS:       rdata = s_q.int_status;
      OFF_TX_SPACE_REQUEST: rdata = s_q.space_req;
      default:              rdata = RESET_WORD;
    endcase
    if (s_q.s2.cmd) begin
      rdata = s_q.addr_word;
    end else if (queue_access) begin
      rdata = RESET_WORD;
    end
    s_d.sd_drive = !s_q.s2.rd_n && !s_q.s2.cs_n;
    s_d.sd_q     = s_d.sd_drive ? rdata : RESET_WORD;
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q       <= '0;
      // sync stages rest at the idle pin level: no false strobe
      s_q.s1    <= PIN_IDLE;
      s_q.s2    <= PIN_IDLE;
      s_q.wr_n3 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // queue memory write port
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      qmem[mem_waddr] <= s_q.s2.sd;
    end
  end

  // ----------------------------------------------------------------
  // fifo toward the mac
  // ----------------------------------------------------------------
  txq_fifo #(
    .WIDTH ($bits(fifo_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (mac_valid),
    .out_ready (mac_ready),
    .out_data  (fifo_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_done_irq_set: // R7
    assert property (@(posedge core_clk) disable iff (reset)
      done && s_q.ctrl[CW_IRQ] |=> s_q.int_status[INT_TX_DONE])
      else $error("done interrupt not raised");

  a_status_tag: // R8
    assert property (@(posedge core_clk) disable iff (reset)
      s_q.st == RD_LEN |=> s_q.status_busy &&
        s_q.status_tag == $past(s_q.ctrl[5:0]))
      else $error("status tag does not match frame");

  a_manual_clear: // R16
    assert property (@(posedge core_clk) disable iff (reset)
      done && s_q.frames == 8'h01 && !commit_ok
        |=> !s_q.txq_cmd[QC_MANUAL])
      else $error("manual enqueue did not self clear");

  a_space_irq: // R17
    assert property (@(posedge core_clk) disable iff (reset)
      space_hit |=> s_q.int_status[INT_SPACE] &&
        !s_q.txq_cmd[QC_SPACE])
      else $error("space interrupt missing");

  a_w1c_clear: // R22
    assert property (@(posedge core_clk) disable iff (reset)
      int_clear[INT_SPACE] && !space_hit |=> !s_q.int_status[INT_SPACE])
      else $error("write one did not clear status");

  a_ptr_step: // R20
    assert property (@(posedge core_clk) disable iff (reset)
      mem_we && s_q.autoinc |=> s_q.ptr == $past(s_q.ptr) + 11'h002)
      else $error("pointer did not advance");

  a_used_bound: // R3
    assert property (@(posedge core_clk) disable iff (reset)
      s_q.used <= QUEUE_WORDS)
      else $error("queue overrun");

  a_idle_disabled: // R13
    assert property (@(posedge core_clk) disable iff (reset)
      !s_q.tx_control[TXC_BLOCK_EN] && s_q.st == RD_IDLE
        |=> s_q.st == RD_IDLE)
      else $error("reader started while disabled");

  a_mac_hold: // R12
    assert property (@(posedge core_clk) disable iff (reset)
      mac_valid && !mac_ready |=> mac_valid && $stable(mac_data))
      else $error("mac data changed while stalled");

  a_space_release: // R24
    assert property (@(posedge core_clk) disable iff (reset)
      done && !commit_ok |=> s_q.used == $past(s_q.used) -
        $past(done_words))
      else $error("frame storage not released");
endmodule

// ---- src/txq_pkg.sv ----
// package: constants and carriers of the transmit queue
package txq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TX_CONTROL       = 8'h70;
  localparam logic [7:0] OFF_TX_STATUS        = 8'h72;
  localparam logic [7:0] OFF_TX_FREE_SPACE    = 8'h78;
  localparam logic [7:0] OFF_TX_QUEUE_COMMAND = 8'h80;
  localparam logic [7:0] OFF_RX_QUEUE_COMMAND = 8'h82;
  localparam logic [7:0] OFF_TX_DATA_POINTER  = 8'h84;
  localparam logic [7:0] OFF_INT_ENABLE       = 8'h90;
  localparam logic [7:0] OFF_INT_STATUS       = 8'h92;
  localparam logic [7:0] OFF_TX_SPACE_REQUEST = 8'h9e;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int TXC_BLOCK_EN = 0;   // tx_control: transmit block
  localparam int TXC_CRC      = 1;   // tx_control: crc generation
  localparam int TXC_PAD      = 2;   // tx_control: padding
  localparam int TXC_FLOW     = 3;   // tx_control: flow control
  localparam int TXC_CSUM_LO  = 5;   // tx_control: checksums 8:5
  localparam int QC_MANUAL    = 0;   // tx_queue_command bits
  localparam int QC_SPACE     = 1;
  localparam int QC_AUTO      = 2;
  localparam int RQ_SESSION   = 3;   // rx_queue_command session
  localparam int DP_AUTOINC   = 14;  // tx_data_pointer auto step
  localparam int INT_TX_DONE  = 14;  // int_status / int_enable
  localparam int INT_SPACE    = 6;
  localparam int CW_IRQ       = 15;  // control word irq_on_complete
  localparam int STATUS_BUSY  = 15;  // tx_status frame in flight
  localparam logic [15:0] TX_CONTROL_MASK = 16'h01ef;
  localparam logic [15:0] INT_MASK        = 16'h4040;

  // ----------------------------------------------------------------
  // sizes and values after reset
  // ----------------------------------------------------------------
  localparam logic [11:0] QUEUE_WORDS = 12'hc00;  // 6 KB in words
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [15:0] RESET_WORD  = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b000,
    RD_CTRL  = 3'b001,
    RD_LEN   = 3'b010,
    RD_DATA  = 3'b011,
    RD_DRAIN = 3'b100
  } rd_state_e;

  typedef struct packed {
    logic        cmd;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [15:0] sd;
  } pin_s;

  // pins at rest: select and strobes high, so reset makes no edge
  localparam pin_s PIN_IDLE = '{cmd: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
                                wr_n: 1'b1, sd: 16'h0000};

  typedef struct packed {
    logic       flow_en;
    logic       pad_en;
    logic       crc_en;
    logic [3:0] csum_en;
  } mac_cfg_s;

  typedef struct packed {
    logic        last;
    logic [15:0] data;
  } fifo_word_s;

endpackage
